//--- pwmss_pkg.sv
// Package with the register map, field layout, reset values and carriers of the PWM shutdown and steering block.
package pwmss_pkg;

  // ==========================================================================
  // Register byte offsets on the APB.
  localparam logic [7:0] PWMSS_OFF_ASD = 8'h00;
  localparam logic [7:0] PWMSS_OFF_EPWM = 8'h04;
  localparam logic [7:0] PWMSS_OFF_STEER = 8'h08;
  localparam logic [7:0] PWMSS_OFF_MODE = 8'h0C;
  localparam logic [7:0] PWMSS_OFF_INT_STATUS = 8'h10;
  localparam logic [7:0] PWMSS_OFF_INT_MASK = 8'h14;

  // ==========================================================================
  // Field positions.
  localparam int PWMSS_ASD_FLAG = 7;
  localparam int PWMSS_ASD_SRC_LO = 4;
  localparam int PWMSS_ASD_AC_LO = 2;
  localparam int PWMSS_ASD_BD_LO = 0;
  localparam int PWMSS_EPWM_RESTART = 7;
  localparam int PWMSS_STEER_SYNC = 4;
  localparam int PWMSS_MODE_CFG_LO = 6;
  localparam int PWMSS_MODE_CSYNC = 4;
  localparam int PWMSS_INT_SHUTDOWN = 0;
  localparam int PWMSS_INT_STEER = 1;

  // ==========================================================================
  // Reset values and codes.
  localparam logic [7:0] PWMSS_RST_ASD = 8'h00;
  localparam logic [7:0] PWMSS_RST_EPWM = 8'h00;
  localparam logic [4:0] PWMSS_RST_STEER = 5'h01;
  localparam logic [7:0] PWMSS_RST_MODE = 8'h00;
  localparam logic [1:0] PWMSS_MODE_PWM = 2'h3;
  localparam logic [1:0] PWMSS_CFG_SINGLE = 2'h0;
  localparam logic [1:0] PWMSS_CFG_FWD = 2'h1;
  localparam logic [1:0] PWMSS_CFG_HALF = 2'h2;
  localparam logic [1:0] PWMSS_CFG_REV = 2'h3;
  localparam logic [1:0] PWMSS_SD_LOW = 2'h0;
  localparam logic [1:0] PWMSS_SD_HIGH = 2'h1;
  localparam int PWMSS_NPINS = 4;
  localparam int PWMSS_NINT = 2;

  // Pin drive of the four outputs A, B, C, D (index 0 to 3).
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pwmss_pins_t;

endpackage : pwmss_pkg

//--- pwmss_ctrl.sv
// Shutdown, restart, delay and steering control of an enhanced PWM channel with an APB register slave.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module pwmss_ctrl
#(
  parameter int DELAY_W = 7
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_in,
  input wire logic pwm_period_start,
  input wire logic comparator_one,
  input wire logic comparator_two,
  input wire logic fault_input_pin_n,
  input wire logic timer1_tick,
  input wire pwmss_pkg::pwmss_pins_t port_pins,
  output pwmss_pkg::pwmss_pins_t pwm_pins,
  output logic irq
);
  import pwmss_pkg::*;

  // ==========================================================================
  // Registers.
  logic [7:0] auto_shutdown_control;
  logic [7:0] enhanced_pwm_control;
  logic [4:0] output_steering_control;
  logic [7:0] mode_control;
  logic [PWMSS_NINT-1:0] int_status;
  logic [PWMSS_NINT-1:0] int_mask;
  logic [3:0] active_steer;
  logic cmp_one_sync;
  logic cmp_two_sync;

  // Field views.
  logic shutdown_event_flag;
  logic [2:0] shutdown_source_select;
  logic [1:0] ac_pair_shutdown_state;
  logic [1:0] bd_pair_shutdown_state;
  logic auto_restart_enable;
  logic [DELAY_W-1:0] activation_delay_count;
  logic steering_sync_select;
  logic [3:0] module_mode_select;
  logic [1:0] output_config_select;
  logic comparator_sync_enable;

  assign shutdown_event_flag = auto_shutdown_control[PWMSS_ASD_FLAG];
  assign shutdown_source_select = auto_shutdown_control[PWMSS_ASD_SRC_LO +: 3];
  assign ac_pair_shutdown_state = auto_shutdown_control[PWMSS_ASD_AC_LO +: 2];
  assign bd_pair_shutdown_state = auto_shutdown_control[PWMSS_ASD_BD_LO +: 2];
  assign auto_restart_enable = enhanced_pwm_control[PWMSS_EPWM_RESTART];
  assign activation_delay_count = enhanced_pwm_control[DELAY_W-1:0];
  assign steering_sync_select = output_steering_control[PWMSS_STEER_SYNC];
  assign module_mode_select = mode_control[3:0];
  assign output_config_select = mode_control[PWMSS_MODE_CFG_LO +: 2];
  assign comparator_sync_enable = mode_control[PWMSS_MODE_CSYNC];

  // ==========================================================================
  // APB decode: zero-wait answer, prepared in the setup cycle.
  logic setup_phase;
  logic wr_access;
  logic addr_hit;
  logic [31:0] next_prdata;

  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite && clk_en;

  // Read mux; also tells whether the address is mapped.
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      PWMSS_OFF_ASD: next_prdata[7:0] = auto_shutdown_control;
      PWMSS_OFF_EPWM: next_prdata[7:0] = enhanced_pwm_control;
      PWMSS_OFF_STEER: next_prdata[4:0] = output_steering_control;
      PWMSS_OFF_MODE: next_prdata[7:0] = mode_control;
      PWMSS_OFF_INT_STATUS: next_prdata[PWMSS_NINT-1:0] = int_status;
      PWMSS_OFF_INT_MASK: next_prdata[PWMSS_NINT-1:0] = int_mask;
      default: addr_hit = 1'b0;
    endcase
  end

  // Bus answer flops: pready and pslverr stand for the access cycle only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_hit;
      if (setup_phase && !pwrite)
      begin
        prdata <= next_prdata;
      end
    end
  end

  logic wr_asd;
  logic wr_epwm;
  logic wr_steer;
  logic wr_mode;
  logic wr_istat;
  logic wr_imask;
  assign wr_asd = wr_access && (paddr == PWMSS_OFF_ASD);
  assign wr_epwm = wr_access && (paddr == PWMSS_OFF_EPWM);
  assign wr_steer = wr_access && (paddr == PWMSS_OFF_STEER);
  assign wr_mode = wr_access && (paddr == PWMSS_OFF_MODE);
  assign wr_istat = wr_access && (paddr == PWMSS_OFF_INT_STATUS);
  assign wr_imask = wr_access && (paddr == PWMSS_OFF_INT_MASK);

  // ==========================================================================
  // Shutdown sources.
  logic cmp_one;
  logic cmp_two;
  logic src_active;
  logic next_flag;

  // Comparator outputs are resampled on the Timer1 tick when sync is on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_one_sync <= 1'b0;
      cmp_two_sync <= 1'b0;
    end
    else if (clk_en && timer1_tick)
    begin
      cmp_one_sync <= comparator_one;
      cmp_two_sync <= comparator_two;
    end
  end

  assign cmp_one = comparator_sync_enable ? cmp_one_sync : comparator_one;
  assign cmp_two = comparator_sync_enable ? cmp_two_sync : comparator_two;

  // Source select bit 2 picks the fault pin, bits 0 and 1 the comparators.
  assign src_active = (shutdown_source_select[2] && !fault_input_pin_n)
                   || (shutdown_source_select[0] && cmp_one)
                   || (shutdown_source_select[1] && cmp_two);

  // A live source outranks restart and any software write to the flag.
  always_comb
  begin
    if (src_active)
    begin
      next_flag = 1'b1;
    end
    else if (auto_restart_enable)
    begin
      next_flag = 1'b0;
    end
    else if (wr_asd)
    begin
      next_flag = pwdata[PWMSS_ASD_FLAG];
    end
    else
    begin
      next_flag = shutdown_event_flag;
    end
  end

  // Control registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_shutdown_control <= PWMSS_RST_ASD;
      enhanced_pwm_control <= PWMSS_RST_EPWM;
      output_steering_control <= PWMSS_RST_STEER;
      mode_control <= PWMSS_RST_MODE;
      int_mask <= '0;
    end
    else if (clk_en)
    begin
      auto_shutdown_control[PWMSS_ASD_FLAG] <= next_flag;
      if (wr_asd)
      begin
        auto_shutdown_control[6:0] <= pwdata[6:0];
      end
      if (wr_epwm)
      begin
        enhanced_pwm_control <= pwdata[7:0];
      end
      if (wr_steer)
      begin
        output_steering_control <= pwdata[4:0];
      end
      if (wr_mode)
      begin
        mode_control <= {pwdata[7:6], 1'b0, pwdata[4:0]};
      end
      if (wr_imask)
      begin
        int_mask <= pwdata[PWMSS_NINT-1:0];
      end
    end
  end

  // ==========================================================================
  // Steering enables in force: at once, or held until the next period start.
  logic steer_apply;
  assign steer_apply = (!steering_sync_select || pwm_period_start)
                    && (active_steer != output_steering_control[3:0]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_steer <= PWMSS_RST_STEER[3:0];
    end
    else if (clk_en && steer_apply)
    begin
      active_steer <= output_steering_control[3:0];
    end
  end

  // ==========================================================================
  // Interrupt status, write one to clear; a new event wins over the clear.
  logic [PWMSS_NINT-1:0] events;
  logic irq_cond;
  assign events[PWMSS_INT_SHUTDOWN] = next_flag && !shutdown_event_flag;
  assign events[PWMSS_INT_STEER] = steer_apply;
  assign irq_cond = |(int_status & int_mask);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status <= '0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      int_status <= (int_status & ~(wr_istat ? pwdata[PWMSS_NINT-1:0] : '0)) | events;
      irq <= irq_cond;
    end
  end

  // ==========================================================================
  // Active-edge delay for the main waveform and its complement.
  logic [1:0] chan_raw;
  logic [1:0] chan_prev;
  logic [1:0] chan_rise;
  logic [1:0] delayed;
  assign chan_raw = {!pwm_in, pwm_in};

  for (genvar g = 0; g < 2; g++)
  begin : g_delay
    logic [DELAY_W-1:0] cnt;
    assign chan_rise[g] = chan_raw[g] && !chan_prev[g];
    // Active only once the count has run out; inactive edges pass at once.
    assign delayed[g] = chan_raw[g] && (chan_rise[g] ? (activation_delay_count == '0) : (cnt == '0));
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        chan_prev[g] <= 1'b0;
        cnt <= '0;
      end
      else if (clk_en)
      begin
        chan_prev[g] <= chan_raw[g];
        // The rise cycle itself counts as the first delay cycle.
        if (chan_rise[g])
        begin
          cnt <= (activation_delay_count == '0) ? '0 : activation_delay_count - 1'b1;
        end
        else if (!chan_raw[g])
        begin
          cnt <= '0;
        end
        else if (cnt != '0)
        begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Pin drive: configuration, steering, polarity, then shutdown override.
  logic pwm_mode;
  logic [3:0] use_pwm;
  logic [3:0] level;
  logic [3:0] invert;
  pwmss_pins_t next_pins;
  assign pwm_mode = (module_mode_select[3:2] == PWMSS_MODE_PWM);
  assign invert = {module_mode_select[0], module_mode_select[1],
                   module_mode_select[0], module_mode_select[1]};

  // Per-configuration pin roles; level is the active-high drive.
  always_comb
  begin
    use_pwm = 4'h0;
    level = 4'h0;
    unique case (output_config_select)
      PWMSS_CFG_SINGLE:
      begin
        use_pwm = active_steer;
        level = {4{delayed[0]}};
      end
      PWMSS_CFG_FWD:
      begin
        use_pwm = 4'hF;
        level = {delayed[0], 2'b00, 1'b1};
      end
      PWMSS_CFG_HALF:
      begin
        use_pwm = 4'h3;
        level = {2'b00, delayed[1], delayed[0]};
      end
      PWMSS_CFG_REV:
      begin
        use_pwm = 4'hF;
        level = {1'b0, 1'b1, delayed[0], 1'b0};
      end
    endcase
  end

  always_comb
  begin
    for (int i = 0; i < PWMSS_NPINS; i++)
    begin
      logic [1:0] sd;
      sd = (i % 2 == 0) ? ac_pair_shutdown_state : bd_pair_shutdown_state;
      if (pwm_mode && next_flag)
      begin
        next_pins.oe[i] = !sd[1];
        next_pins.out[i] = (sd == PWMSS_SD_HIGH);
      end
      else if (pwm_mode && use_pwm[i])
      begin
        next_pins.oe[i] = 1'b1;
        next_pins.out[i] = level[i] ^ invert[i];
      end
      else
      begin
        next_pins.oe[i] = port_pins.oe[i];
        next_pins.out[i] = port_pins.out[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_pins <= '0;
    end
    else if (clk_en)
    begin
      pwm_pins <= next_pins;
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_live_source;
    clk_en && src_active;
  endsequence

  a_src_off_quiet: assert property (clk_en && shutdown_source_select == 3'b000 && !wr_asd && !shutdown_event_flag
    |=> !shutdown_event_flag) else $error("flag set with sources off");
  a_fault_trips: assert property (clk_en && shutdown_source_select[2] && !fault_input_pin_n
    |=> shutdown_event_flag) else $error("fault pin did not trip");
  a_cmp_direct: assert property (clk_en && !comparator_sync_enable && shutdown_source_select == 3'b001 && comparator_one
    |=> shutdown_event_flag) else $error("comparator one did not trip");
  a_clear_blocked: assert property (s_live_source |=> shutdown_event_flag)
    else $error("flag cleared while source active");
  a_auto_restart: assert property (clk_en && auto_restart_enable && !src_active
    |=> !shutdown_event_flag) else $error("auto restart did not clear flag");
  a_flag_holds: assert property (clk_en && shutdown_event_flag && !auto_restart_enable && !src_active && !wr_asd
    |=> shutdown_event_flag) else $error("flag dropped without software");
  a_sd_low_ac: assert property ($rose(shutdown_event_flag) && $past(pwm_mode) && $past(ac_pair_shutdown_state) == 2'b00
    |-> pwm_pins.oe[0] && !pwm_pins.out[0] && pwm_pins.oe[2] && !pwm_pins.out[2])
    else $error("A/C not low in shutdown");
  a_sd_tri_bd: assert property ($rose(shutdown_event_flag) && $past(pwm_mode) && $past(bd_pair_shutdown_state[1])
    |-> !pwm_pins.oe[1] && !pwm_pins.oe[3]) else $error("B/D not tri-state in shutdown");
  a_steer_held: assert property (clk_en && steering_sync_select && !pwm_period_start
    |=> $stable(active_steer)) else $error("steering changed mid-period");
  a_steer_now: assert property (clk_en && !steering_sync_select && !wr_steer
    |=> active_steer == $past(output_steering_control[3:0])) else $error("steering not applied");
  a_delay_hold: assert property (chan_rise[0] && activation_delay_count != '0 |-> !delayed[0])
    else $error("active edge not delayed");
  a_irq_level: assert property (clk_en |=> irq == $past(irq_cond)) else $error("irq not following status");

endmodule : pwmss_ctrl

//--- pwmss_bridge_model.sv
// Model of the external bridge driver stage fed by the four PWM pins.
`timescale 1ns/1ps
module pwmss_bridge_model
(
  input wire pwmss_pkg::pwmss_pins_t pins,
  output logic [3:0] gate
);
  import pwmss_pkg::*;

  // ==========================================================================
  // Gate inputs
  // The gate inputs have pull-downs, so a released pin reads low at the bridge.
  always_comb
  begin
    gate = pins.out & pins.oe;
  end
endmodule : pwmss_bridge_model

//--- pwmss_ctrl_bench.sv
// Self-checking bench of the PWM shutdown and steering control.
`timescale 1ns/1ps
module pwmss_ctrl_bench;
  import pwmss_pkg::*;

  // ==========================================================================
  // Table of shutdown source cases
  typedef struct packed {
    logic [2:0] src;
    logic c1;
    logic c2;
    logic fn;
    logic [3:0] st;
    logic flag;
  } pwmss_row_t;
  localparam pwmss_row_t ROWS [14] = '{
    '{3'h0, 1'b1, 1'b1, 1'b0, 4'h4, 1'b0}, '{3'h1, 1'b1, 1'b0, 1'b1, 4'h4, 1'b1},
    '{3'h1, 1'b0, 1'b1, 1'b1, 4'h1, 1'b0}, '{3'h2, 1'b0, 1'b1, 1'b1, 4'h1, 1'b1},
    '{3'h2, 1'b1, 1'b0, 1'b1, 4'hB, 1'b0}, '{3'h3, 1'b1, 1'b0, 1'b1, 4'hB, 1'b1},
    '{3'h3, 1'b0, 1'b1, 1'b1, 4'h6, 1'b1}, '{3'h4, 1'b0, 1'b0, 1'b0, 4'h9, 1'b1},
    '{3'h4, 1'b1, 1'b1, 1'b1, 4'h6, 1'b0}, '{3'h5, 1'b1, 1'b0, 1'b1, 4'h4, 1'b1},
    '{3'h6, 1'b0, 1'b1, 1'b1, 4'h1, 1'b1}, '{3'h6, 1'b1, 1'b0, 1'b1, 4'h4, 1'b0},
    '{3'h7, 1'b0, 1'b1, 1'b1, 4'hB, 1'b1}, '{3'h7, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1}};

  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, irq, rerr;
  logic pwm_in = 1'b0, period = 1'b0, tick = 1'b0, c1 = 1'b0, c2 = 1'b0, fault_n = 1'b1;
  pwmss_pins_t port_pins = 8'hEF;
  pwmss_pins_t pwm_pins;
  logic [3:0] gate;
  logic [7:0] exp;
  int errors = 0, n_checks = 0, cycles = 0, n;

  pwmss_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_in(pwm_in), .pwm_period_start(period), .comparator_one(c1), .comparator_two(c2),
    .fault_input_pin_n(fault_n), .timer1_tick(tick), .port_pins(port_pins), .pwm_pins(pwm_pins), .irq(irq));
  pwmss_bridge_model i_bridge (.pins(pwm_pins), .gate(gate));

  // Clock of 100 ns period.
  always #50 pclk = ~pclk;

  // Cuts a hung run short.
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      errors = errors + 1;
      wrap_up;
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
    n_checks++;
    if (got !== want)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, got);
    end
  endtask : chk

  // One APB transfer; data and response are taken at the edge that samples pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    chk("pready", 32'h1, {31'h0, pready});
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), want, rdata);
  endtask : rd

  // Pins are looked at on the falling edge, where they are settled.
  task automatic pchk(input logic [3:0] oe, input logic [3:0] lvl);
    @(negedge pclk);
    chk("pin enables", {28'h0, oe}, {28'h0, pwm_pins.oe});
    chk("bridge gates", {28'h0, lvl}, {28'h0, gate});
  endtask : pchk

  // Expected enables and levels of the pins in shutdown, from the two state fields.
  function automatic logic [7:0] sd_pins(input logic [3:0] st);
    logic ac, bd;
    ac = (st[3:2] == 2'b01);
    bd = (st[1:0] == 2'b01);
    return {~st[1], ~st[3], ~st[1], ~st[3], bd, ac, bd, ac};
  endfunction : sd_pins

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(PWMSS_OFF_ASD, 32'h00);
    rd(PWMSS_OFF_EPWM, 32'h00);
    rd(PWMSS_OFF_STEER, 32'h01);
    rd(PWMSS_OFF_MODE, 32'h00);
    wr(PWMSS_OFF_STEER, 32'hFF);
    rd(PWMSS_OFF_STEER, 32'h1F);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    wr(PWMSS_OFF_STEER, 32'h01);
    wr(PWMSS_OFF_MODE, 32'h0C);
    wr(PWMSS_OFF_EPWM, 32'h80);
    wr(PWMSS_OFF_INT_MASK, 32'h01);
    $display("Test registers done");
    foreach (ROWS[i])
    begin
      wr(PWMSS_OFF_ASD, {24'h0, 1'b0, ROWS[i].src, ROWS[i].st});
      @(posedge pclk);
      c1 <= ROWS[i].c1;
      c2 <= ROWS[i].c2;
      fault_n <= ROWS[i].fn;
      exp = ROWS[i].flag ? sd_pins(ROWS[i].st) : 8'hFE;
      @(posedge pclk);
      pchk(exp[7:4], exp[3:0]);
      rd(PWMSS_OFF_ASD, {24'h0, ROWS[i].flag, ROWS[i].src, ROWS[i].st});
      @(posedge pclk);
      c1 <= 1'b0;
      c2 <= 1'b0;
      fault_n <= 1'b1;
      repeat (2) @(posedge pclk);
      pchk(4'hF, 4'hE);
    end
    $display("Test source table done");
    wr(PWMSS_OFF_EPWM, 32'h00);
    wr(PWMSS_OFF_INT_STATUS, 32'h03);
    wr(PWMSS_OFF_ASD, 32'h44);
    @(posedge pclk);
    fault_n <= 1'b0;
    @(posedge pclk);
    pchk(4'hF, 4'h5);
    wr(PWMSS_OFF_ASD, 32'h44);
    rd(PWMSS_OFF_ASD, 32'hC4);
    chk("irq raised", 32'h1, {31'h0, irq});
    @(posedge pclk);
    fault_n <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(PWMSS_OFF_ASD, 32'hC4);
    pchk(4'hF, 4'h5);
    wr(PWMSS_OFF_ASD, 32'h44);
    rd(PWMSS_OFF_ASD, 32'h44);
    pchk(4'hF, 4'hE);
    wr(PWMSS_OFF_INT_MASK, 32'h00);
    repeat (2) @(negedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(PWMSS_OFF_INT_STATUS, 32'h01);
    wr(PWMSS_OFF_INT_STATUS, 32'h01);
    rd(PWMSS_OFF_INT_STATUS, 32'h00);
    wr(PWMSS_OFF_INT_MASK, 32'h01);
    $display("Test manual restart done");
    wr(PWMSS_OFF_EPWM, 32'h80);
    wr(PWMSS_OFF_MODE, 32'h1C);
    wr(PWMSS_OFF_ASD, 32'h14);
    @(posedge pclk);
    c1 <= 1'b1;
    repeat (3) @(posedge pclk);
    pchk(4'hF, 4'hE);
    @(posedge pclk);
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    @(posedge pclk);
    pchk(4'hF, 4'h5);
    @(posedge pclk);
    c1 <= 1'b0;
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    repeat (2) @(posedge pclk);
    pchk(4'hF, 4'hE);
    wr(PWMSS_OFF_MODE, 32'h0C);
    $display("Test comparator sync done");
    @(posedge pclk);
    pwm_in <= 1'b1;
    repeat (2) @(posedge pclk);
    pchk(4'hF, 4'hF);
    wr(PWMSS_OFF_STEER, 32'h12);
    repeat (3) @(posedge pclk);
    pchk(4'hF, 4'hF);
    @(posedge pclk);
    period <= 1'b1;
    @(posedge pclk);
    period <= 1'b0;
    @(posedge pclk);
    pchk(4'hF, 4'hE);
    wr(PWMSS_OFF_MODE, 32'h0D);
    repeat (2) @(posedge pclk);
    pchk(4'hF, 4'hC);
    wr(PWMSS_OFF_STEER, 32'h05);
    repeat (2) @(posedge pclk);
    pchk(4'hF, 4'hF);
    wr(PWMSS_OFF_MODE, 32'h4C);
    repeat (3) @(posedge pclk);
    pchk(4'hF, 4'h9);
    wr(PWMSS_OFF_MODE, 32'h0C);
    wr(PWMSS_OFF_STEER, 32'h01);
    $display("Test steering done");
    wr(PWMSS_OFF_EPWM, 32'h05);
    @(posedge pclk);
    pwm_in <= 1'b0;
    repeat (3) @(posedge pclk);
    pwm_in <= 1'b1;
    for (n = 1; n <= 20; n++)
    begin
      @(negedge pclk);
      if (gate[0] === 1'b1)
        break;
    end
    chk("delay cycles", 32'd7, n);
    @(posedge pclk);
    pwm_in <= 1'b0;
    @(posedge pclk);
    pchk(4'hF, 4'hE);
    $display("Test delay done");
    @(posedge pclk);
    clk_en <= 1'b0;
    c1 <= 1'b1;
    repeat (2) @(posedge pclk);
    pchk(4'hF, 4'hE);
    @(posedge pclk);
    c1 <= 1'b0;
    clk_en <= 1'b1;
    $display("Test clock enable done");
    @(posedge pclk);
    presetn <= 1'b0;
    pchk(4'h0, 4'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(PWMSS_OFF_STEER, 32'h01);
    rd(PWMSS_OFF_EPWM, 32'h00);
    rd(PWMSS_OFF_MODE, 32'h00);
    $display("Test second reset done");
    wrap_up;
  end
endmodule : pwmss_ctrl_bench
